// file: verilog/fgm_cfg.svh
/*
  constants for the fsk / gfsk divider modulator: register offsets,
  field positions, reset values and shaping figures.
  assumes inclusion by bare name from the modules that use it.
*/
`ifndef FGM_CFG_SVH
`define FGM_CFG_SVH

// register byte addresses
`define FGM_ADDR_TX_CFG_ONE 8'h05
`define FGM_ADDR_FRAC_TOP_A 8'h0C
`define FGM_ADDR_FRAC_TOP_B 8'h10
`define FGM_ADDR_FRAC_TOP_C 8'h14
`define FGM_ADDR_FRAC_TOP_D 8'h18
`define FGM_ADDR_DEV        8'h1C
`define FGM_ADDR_STEP_DIV_LO 8'h1D
`define FGM_ADDR_SHAPE_CFG  8'h1E
// second setup copies, channel words and status, chosen offsets
`define FGM_ADDR_TX_CFG_ONE_B 8'h20
`define FGM_ADDR_DEV_B      8'h21
`define FGM_ADDR_STEP_DIV_LO_B 8'h22
`define FGM_ADDR_SHAPE_B    8'h23
`define FGM_ADDR_CHAN_BASE  8'h30
`define FGM_ADDR_STATUS     8'h40

// field positions
`define FGM_TX_INVERT_BIT   3
`define FGM_TX_FSK_BIT      0
`define FGM_SHAPE_BYP_BIT   3
`define FGM_DEV_SCALE_LSB   5

// reset values
`define FGM_RST_DEV         8'hDF
`define FGM_RST_STEP_DIV_LO 8'h08
`define FGM_RST_SHAPE       8'h00
`define FGM_RST_TX_CFG_ONE 8'h01
`define FGM_RST_FRAC_TOP    8'h10

// shaping figures
`define FGM_SHAPE_STEPS     16
`define FGM_DEV_FACTOR      190
`define FGM_DEV_SCALE_SHIFT 6

`endif

// file: verilog/fgm_pkg.sv
/*
  types for the fsk / gfsk divider modulator.
  assumes the cfg header sits on the include path.
*/
package fgm_pkg;
  // one modulation setup
  typedef struct packed {
    logic [7:0] tx_cfg;
    logic [7:0] dev;
    logic [10:0] shape_div;
    logic shape_bypass;
  } fgm_setup_t;

  // divider word: 7 bit integer, 21 bit fraction
  typedef struct packed {
    logic [6:0] int_part;
    logic [20:0] frac_part;
  } fgm_word_t;

  typedef enum logic [1:0] {
    FGM_ST_IDLE = 2'b00,
    FGM_ST_STEP = 2'b01,
    FGM_ST_HOLD = 2'b10
  } fgm_state_t;
endpackage

// file: verilog/fgm_step_clock.sv
/*
  shaping step clock: one-cycle enable every div+1 reference cycles.
  assumes a single reference clock and synchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fgm_step_clock
  import fgm_pkg::*;
#(
  parameter int DIV_W = 11
)(
  input wire logic i_clock, // reference clock
  input wire logic i_reset_n, // sync reset, active low
  input wire logic i_run, // divider runs while high
  input wire logic [DIV_W-1:0] i_div, // programmed divider value
  output logic o_tick // one-cycle step enable
);
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic next_tick;

  always_comb
  begin
    next_count = count;
    next_tick = 1'b0;
    if (!i_run)
      next_count = '0;
    else if (count >= i_div)
    begin
      next_count = '0;
      next_tick = 1'b1;
    end
    else
      next_count = count + 1'b1;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      count <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      o_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// file: verilog/fgm_dev_calc.sv
/*
  deviation offset: 190 * magnitude * 2^scale / 64, rounded.
  assumes registered inputs; result is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fgm_cfg.svh"
module fgm_dev_calc
  import fgm_pkg::*;
(
  input wire logic [4:0] i_mag, // deviation magnitude
  input wire logic [2:0] i_scale, // deviation scale code
  output logic [20:0] o_offset // offset in fraction lsbs
);
  logic [20:0] prod;

  always_comb
  begin
    prod = 21'(`FGM_DEV_FACTOR) * {16'h0000, i_mag};
    prod = prod << i_scale;
    // half lsb added before dropping six bits
    o_offset = (prod + 21'h00_0020) >> `FGM_DEV_SCALE_SHIFT;
  end
endmodule
`default_nettype wire

// file: verilog/fgm_modulator.sv
/*
  fsk / gfsk divider modulator: registers, two setups, four channels,
  chip to divider word mapping and gaussian step walk.
  assumes the host gives encoded chips, a setup select and a channel
  select synchronous to i_clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fgm_cfg.svh"
// Behaviour
// - with no inversion a one chip selects the upper word, a zero the lower.
// - the invert bit swaps which chip value gives which deviation.
// - mapping acts on encoder chips, which are the i_chip input here.
// - unshaped fsk only switches between two fixed divider words.
// - shaping is on when the bypass bit is zero, off when it is one.
// - a field of transmit config one selects ask or fsk.
// - two setups are held and a host bit picks the active one.
// - offset is magnitude times 190 times two to the scale over 64.
// - in ask mode shaping stays off whatever the bypass bit says.
// - in gfsk the word walks in fixed steps across one chip edge.
// - each transition takes 16 steps paced by the step clock.
// - step clock is the reference divided by divider value plus one.
// - step divider is 11 bits, low byte plus three bits in shape config.
module fgm_modulator
  import fgm_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int STEPS = `FGM_SHAPE_STEPS
)(
  input wire logic i_clock, // reference clock, 50 MHz
  input wire logic i_reset_n, // sync reset, active low
  input wire logic [7:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // register write data
  input wire logic i_write, // write strobe
  input wire logic i_read, // read strobe
  input wire logic i_chip, // encoded chip value
  input wire logic i_setup_sel, // setup select from command
  input wire logic [1:0] i_channel, // active channel
  output logic [7:0] o_rdata, // read data, one cycle later
  output fgm_word_t o_div_word, // divider word to synthesizer
  output logic o_fsk_mode, // fsk selected
  output logic o_shaping // gaussian shaping active
);
  fgm_setup_t setup [2];
  fgm_setup_t next_setup [2];
  logic [7:0] frac_top [CHANNELS];
  logic [7:0] next_frac_top [CHANNELS];
  fgm_word_t nominal [CHANNELS];
  fgm_word_t next_nominal [CHANNELS];
  logic [7:0] next_rdata;

  // channel register decode, used by write and read paths
  function automatic logic [2:0] frac_top_hit(input logic [7:0] a);
    unique case (a)
      `FGM_ADDR_FRAC_TOP_A: frac_top_hit = 3'h4;
      `FGM_ADDR_FRAC_TOP_B: frac_top_hit = 3'h5;
      `FGM_ADDR_FRAC_TOP_C: frac_top_hit = 3'h6;
      `FGM_ADDR_FRAC_TOP_D: frac_top_hit = 3'h7;
      default: frac_top_hit = 3'h0;
    endcase
  endfunction

  // register writes, two setups kept separately
  always_comb
  begin
    logic [2:0] hit;
    hit = frac_top_hit(i_addr);
    next_setup = setup;
    next_frac_top = frac_top;
    next_nominal = nominal;
    if (i_write)
    begin
      unique case (i_addr)
        `FGM_ADDR_TX_CFG_ONE: next_setup[0].tx_cfg = i_wdata;
        `FGM_ADDR_DEV: next_setup[0].dev = i_wdata;
        `FGM_ADDR_STEP_DIV_LO: next_setup[0].shape_div[7:0] = i_wdata;
        // upper divider bits share shape config
        `FGM_ADDR_SHAPE_CFG:
        begin
          next_setup[0].shape_div[10:8] = i_wdata[2:0];
          next_setup[0].shape_bypass = i_wdata[`FGM_SHAPE_BYP_BIT];
        end
        `FGM_ADDR_TX_CFG_ONE_B: next_setup[1].tx_cfg = i_wdata;
        `FGM_ADDR_DEV_B: next_setup[1].dev = i_wdata;
        `FGM_ADDR_STEP_DIV_LO_B: next_setup[1].shape_div[7:0] = i_wdata;
        `FGM_ADDR_SHAPE_B:
        begin
          next_setup[1].shape_div[10:8] = i_wdata[2:0];
          next_setup[1].shape_bypass = i_wdata[`FGM_SHAPE_BYP_BIT];
        end
        default: ;
      endcase
      // chosen map: base + 4*ch + 0..2 for int, frac low, frac mid
      for (int c = 0; c < CHANNELS; c++)
      begin
        if (i_addr == `FGM_ADDR_CHAN_BASE + 8'(4 * c))
          next_nominal[c].int_part = i_wdata[6:0];
        if (i_addr == `FGM_ADDR_CHAN_BASE + 8'(4 * c + 1))
          next_nominal[c].frac_part[7:0] = i_wdata;
        if (i_addr == `FGM_ADDR_CHAN_BASE + 8'(4 * c + 2))
          next_nominal[c].frac_part[15:8] = i_wdata;
        // low five bits are fraction bits 20 to 16
        if (hit[2] && hit[1:0] == 2'(c))
        begin
          next_frac_top[c] = i_wdata;
          next_nominal[c].frac_part[20:16] = i_wdata[4:0];
        end
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      for (int s = 0; s < 2; s++)
      begin
        setup[s].tx_cfg <= `FGM_RST_TX_CFG_ONE;
        setup[s].dev <= `FGM_RST_DEV;
        setup[s].shape_div <= {3'h0, `FGM_RST_STEP_DIV_LO};
        setup[s].shape_bypass <= 1'b0;
      end
      for (int c = 0; c < CHANNELS; c++)
      begin
        frac_top[c] <= `FGM_RST_FRAC_TOP;
        nominal[c] <= {7'h40, 21'h10_0000};
      end
    end
    else
    begin
      setup <= next_setup;
      frac_top <= next_frac_top;
      nominal <= next_nominal;
    end
  end

  // active setup and derived controls
  fgm_setup_t act;
  logic fsk_sel;
  logic shape_en;
  logic want_hi;
  logic [20:0] offset;
  fgm_word_t nom;
  logic [27:0] word_hi;
  logic [27:0] word_lo;

  // host bit picks setup without rewrite
  assign act = setup[i_setup_sel];
  // mode field of transmit config one
  assign fsk_sel = act.tx_cfg[`FGM_TX_FSK_BIT];
  assign shape_en = fsk_sel && !act.shape_bypass;
  assign want_hi = i_chip ^ act.tx_cfg[`FGM_TX_INVERT_BIT];
  assign nom = nominal[i_channel];

  fgm_dev_calc u_dev
  (
    .i_mag(act.dev[4:0]),
    .i_scale(act.dev[7:5]),
    .o_offset(offset)
  );

  assign word_hi = nom + {7'h00, offset};
  assign word_lo = nom - {7'h00, offset};

  // gaussian walk state
  fgm_state_t state;
  fgm_state_t next_state;
  logic [4:0] step;
  logic [4:0] next_step;
  logic target_hi;
  logic next_target_hi;
  fgm_word_t next_div_word;
  logic tick;

  fgm_step_clock #(.DIV_W(11)) u_step
  (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_run(state == FGM_ST_STEP),
    .i_div(act.shape_div),
    .o_tick(tick)
  );

  // step interpolation between low and high word
  function automatic logic [27:0] blend(input logic [27:0] lo,
                                        input logic [27:0] hi,
                                        input logic [4:0] k,
                                        input logic up);
    logic [33:0] span;
    logic [33:0] part;
    span = {6'h00, hi - lo};
    part = (span * {29'h0, k}) >> 4;
    blend = up ? 28'(lo + part[27:0]) : 28'(hi - part[27:0]);
  endfunction

  // next divider word and walk
  always_comb
  begin
    next_state = state;
    next_step = step;
    next_target_hi = target_hi;
    next_div_word = o_div_word;
    // nominal word in ask mode, else only the two words, or steps between them
    if (!fsk_sel)
    begin
      next_state = FGM_ST_IDLE;
      next_div_word = nom;
    end
    else if (!shape_en)
    begin
      // new word on the next cycle
      next_state = FGM_ST_IDLE;
      next_target_hi = want_hi;
      next_div_word = want_hi ? word_hi : word_lo;
    end
    else
    begin
      unique case (state)
        FGM_ST_IDLE, FGM_ST_HOLD:
        begin
          next_div_word = target_hi ? word_hi : word_lo;
          if (want_hi != target_hi)
          begin
            next_state = FGM_ST_STEP;
            next_target_hi = want_hi;
            next_step = 5'h00;
          end
          else
            next_state = FGM_ST_HOLD;
        end
        FGM_ST_STEP:
        begin
          if (tick)
          begin
            next_step = step + 5'h01;
            next_div_word = blend(word_lo, word_hi, step + 5'h01, target_hi);
            if (step + 5'h01 == 5'(STEPS))
              next_state = FGM_ST_HOLD;
          end
        end
        default: next_state = FGM_ST_IDLE;
      endcase
    end
  end

  // read path: status shows live state
  always_comb
  begin
    logic [2:0] hit;
    hit = frac_top_hit(i_addr);
    next_rdata = 8'h00;
    if (i_read)
    begin
      if (hit[2])
        next_rdata = {2'b00, frac_top[hit[1:0]][5:0]};
      else
        unique case (i_addr)
          `FGM_ADDR_TX_CFG_ONE: next_rdata = setup[0].tx_cfg;
          `FGM_ADDR_DEV: next_rdata = setup[0].dev;
          `FGM_ADDR_STEP_DIV_LO: next_rdata = setup[0].shape_div[7:0];
          `FGM_ADDR_SHAPE_CFG: next_rdata = {4'h0, setup[0].shape_bypass,
                                            setup[0].shape_div[10:8]};
          `FGM_ADDR_TX_CFG_ONE_B: next_rdata = setup[1].tx_cfg;
          `FGM_ADDR_DEV_B: next_rdata = setup[1].dev;
          `FGM_ADDR_STEP_DIV_LO_B: next_rdata = setup[1].shape_div[7:0];
          `FGM_ADDR_SHAPE_B: next_rdata = {4'h0, setup[1].shape_bypass,
                                          setup[1].shape_div[10:8]};
          `FGM_ADDR_STATUS: next_rdata = {1'b0, step, state};
          default: next_rdata = 8'h00;
        endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      state <= FGM_ST_IDLE;
      step <= 5'h00;
      target_hi <= 1'b0;
      o_div_word <= '0;
      o_rdata <= 8'h00;
      o_fsk_mode <= 1'b0;
      o_shaping <= 1'b0;
    end
    else
    begin
      state <= next_state;
      step <= next_step;
      target_hi <= next_target_hi;
      o_div_word <= next_div_word;
      o_rdata <= next_rdata;
      o_fsk_mode <= fsk_sel;
      o_shaping <= shape_en;
    end
  end

  // checks
  sequence s_chip_change;
    $changed(i_chip) ##0 $stable(i_setup_sel) ##0 $stable(i_channel);
  endsequence

  a_unshaped_word_hi: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (fsk_sel && !shape_en && want_hi) |=> (o_div_word == $past(word_hi)))
    else $error("unshaped high word not applied");
  a_unshaped_word_lo: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (fsk_sel && !shape_en && !want_hi) |=> (o_div_word == $past(word_lo)))
    else $error("unshaped low word not applied");
  a_ask_no_shape: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !fsk_sel |=> !o_shaping)
    else $error("shaping active in ask mode");
  a_bypass_shape: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (fsk_sel && !act.shape_bypass) |=> o_shaping)
    else $error("shaping off though not bypassed");
  a_invert_swap: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (fsk_sel && !shape_en && act.tx_cfg[`FGM_TX_INVERT_BIT] && i_chip)
      |=> (o_div_word == $past(word_lo)))
    else $error("invert does not swap direction");
  a_word_pair: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (fsk_sel && !shape_en) |=> ((o_div_word == $past(nom) + {7'h00, $past(offset)})
      || (o_div_word == $past(nom) - {7'h00, $past(offset)})))
    else $error("words not symmetric about nominal");
  a_step_limit: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    step <= 5'(STEPS))
    else $error("step count beyond sixteen");
  a_step_end_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state == FGM_ST_STEP && tick && step == 5'(STEPS - 1) && shape_en)
      |=> (state == FGM_ST_HOLD))
    else $error("walk did not end after sixteen steps");
  a_chip_reacts: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (s_chip_change ##0 (fsk_sel && !shape_en && $stable(act))) |=> $changed(o_div_word)
      || (offset == 21'h0))
    else $error("divider word ignored chip change");
endmodule
`default_nettype wire

// file: verification/fgm_host_model.sv
/*
  host chip source: holds a chip level, or toggles the chip at a fixed period.
  assumes the bench clock and a synchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fgm_host_model
#(
  parameter int CHIP_CYC = 48
)(
  input wire logic i_clock, // reference clock
  input wire logic i_reset_n, // sync reset, active low
  input wire logic i_run, // toggle chips while high
  input wire logic i_level, // chip held while not running
  output logic o_chip // encoded chip to modulator
);
  int cnt;

  // chip period 16 steps
  // chips change once per period; a hold just follows the level
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n || !i_run)
    begin
      cnt <= 0;
      o_chip <= i_level;
    end
    else if (cnt == CHIP_CYC - 1)
    begin
      cnt <= 0;
      o_chip <= !o_chip;
    end
    else
      cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

// file: verification/fgm_modulator_test.sv
/*
  self-checking bench for the divider modulator: register port, chip to
  word mapping, setups, channels and the gaussian step walk.
  assumes the design files and the host chip model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fgm_cfg.svh"
module fgm_modulator_test;
  localparam logic [27:0] NOM = 28'h810_0000;
  localparam logic [27:0] NOM2 = 28'h81F_0000;
  typedef struct packed {
    logic [7:0] dv;
    logic inv;
    logic chip;
  } fgm_row_t;
  // rows: deviation byte, invert bit, chip
  fgm_row_t rows [0:7] = '{'{8'hC1, 1'h0, 1'h1}, '{8'hC1, 1'h0, 1'h0},
    '{8'hC1, 1'h1, 1'h1}, '{8'hC1, 1'h1, 1'h0}, '{8'h1F, 1'h0, 1'h1},
    '{8'h65, 1'h1, 1'h0}, '{8'hA4, 1'h0, 1'h0}, '{8'hE3, 1'h1, 1'h1}};
  logic i_clock = 1'h0;
  logic i_reset_n = 1'h0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_write = 1'h0;
  logic i_read = 1'h0;
  logic i_setup_sel = 1'h0;
  logic [1:0] i_channel = 2'h0;
  logic run = 1'h0;
  logic level = 1'h0;
  logic chip;
  logic [7:0] o_rdata;
  logic [27:0] o_div_word;
  logic o_fsk_mode;
  logic o_shaping;
  logic [7:0] rd_val;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  fgm_modulator dut_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .i_chip(chip),
    .i_setup_sel(i_setup_sel), .i_channel(i_channel), .o_rdata(o_rdata),
    .o_div_word(o_div_word), .o_fsk_mode(o_fsk_mode), .o_shaping(o_shaping));
  fgm_host_model #(.CHIP_CYC(48)) host_u (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_run(run), .i_level(level), .o_chip(chip));

  // 50 MHz reference
  always #10 i_clock = ~i_clock;

  // hang guard, well above the ~5100 cycles the run needs
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [27:0] e, input logic [27:0] s);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'h1;
    @(posedge i_clock);
    i_write <= 1'h0;
    @(posedge i_clock);
  endtask

  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_read <= 1'h1;
    @(posedge i_clock);
    i_read <= 1'h0;
    #1;
    rd_val = o_rdata;
    @(posedge i_clock);
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // expected word: nominal plus or minus rounded 190*mag*2^scale/64
  function automatic logic [27:0] wexp(input logic [27:0] nom, input logic [7:0] dv,
    input logic up);
    logic [27:0] off;
    off = (28'hBE * dv[4:0] * (28'h1 << dv[7:5]) + 28'h20) / 28'h40;
    return up ? nom + off : nom - off;
  endfunction

  // counts word moves after a chip edge and the span of the steps
  task automatic walk(input string n, input int step, input logic [27:0] fin);
    logic [27:0] prev;
    int moves;
    int first;
    int last;
    #1;
    prev = o_div_word;
    moves = 0;
    first = 0;
    last = 0;
    for (int c = 0; c < 17 * step + 20; c++)
    begin
      look(1);
      if (o_div_word !== prev)
      begin
        if (moves == 0)
          first = c;
        last = c;
        moves++;
      end
      prev = o_div_word;
    end
    chk(n, 28'h10, 28'(moves));
    chk(n, 28'(15 * step), 28'(last - first));
    chk(n, fin, o_div_word);
    @(posedge i_clock);
  endtask

  initial
  begin
    logic up;
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'h1;
    look(2);
    chk("fsk_reset", 28'h1, o_fsk_mode);
    chk("shaping_reset", 28'h1, o_shaping);
    chk("rdata_idle", 28'h0, o_rdata);
    @(posedge i_clock);
    rd(`FGM_ADDR_FRAC_TOP_A);
    chk("frac_top_reset", 28'h10, rd_val);
    wr(8'h7F, 8'hAA);
    rd(8'h7F);
    chk("unmapped", 28'h0, rd_val);
    wr(`FGM_ADDR_SHAPE_CFG, 8'h08);
    // table rows: unshaped mapping, one cycle latency
    for (int k = 0; k < 8; k++)
    begin
      up = rows[k].chip ^ rows[k].inv;
      wr(`FGM_ADDR_DEV, rows[k].dv);
      wr(`FGM_ADDR_TX_CFG_ONE, {4'h0, rows[k].inv, 3'h1});
      level <= !rows[k].chip;
      repeat (4) @(posedge i_clock);
      level <= rows[k].chip;
      look(1);
      chk("word_held", wexp(NOM, rows[k].dv, !up), o_div_word);
      look(1);
      chk("word_row", wexp(NOM, rows[k].dv, up), o_div_word);
      @(posedge i_clock);
    end
    // channel nominal words
    wr(`FGM_ADDR_DEV, 8'hC1);
    wr(`FGM_ADDR_TX_CFG_ONE, 8'h01);
    level <= 1'h1;
    wr(`FGM_ADDR_FRAC_TOP_A, 8'h1F);
    rd(`FGM_ADDR_FRAC_TOP_A);
    chk("frac_top", 28'h1F, rd_val);
    look(1);
    chk("nominal_a", NOM2 + 28'hBE, o_div_word);
    @(posedge i_clock);
    i_channel <= 2'h1;
    look(3);
    chk("nominal_b", NOM + 28'hBE, o_div_word);
    @(posedge i_clock);
    // second setup, ask mode
    wr(`FGM_ADDR_TX_CFG_ONE_B, 8'h01);
    wr(`FGM_ADDR_DEV_B, 8'hE3);
    wr(`FGM_ADDR_SHAPE_B, 8'h08);
    i_setup_sel <= 1'h1;
    look(3);
    chk("setup_two", NOM + 28'h474, o_div_word);
    chk("bypass_two", 28'h0, o_shaping);
    @(posedge i_clock);
    wr(`FGM_ADDR_SHAPE_B, 8'h00);
    look(2);
    chk("shape_two", 28'h1, o_shaping);
    @(posedge i_clock);
    wr(`FGM_ADDR_TX_CFG_ONE_B, 8'h00);
    look(2);
    chk("ask_mode", 28'h0, o_fsk_mode);
    chk("ask_shaping", 28'h0, o_shaping);
    @(posedge i_clock);
    i_setup_sel <= 1'h0;
    i_channel <= 2'h0;
    look(3);
    chk("setup_one", 28'h1, o_fsk_mode);
    chk("shaping_one", 28'h0, o_shaping);
    @(posedge i_clock);
    // gaussian walks: short divider, then a 9 bit divider
    wr(`FGM_ADDR_STEP_DIV_LO, 8'h02);
    wr(`FGM_ADDR_SHAPE_CFG, 8'h00);
    repeat (60) @(posedge i_clock);
    level <= 1'h0;
    walk("walk_fast", 3, NOM2 - 28'hBE);
    wr(`FGM_ADDR_STEP_DIV_LO, 8'h00);
    wr(`FGM_ADDR_SHAPE_CFG, 8'h01);
    level <= 1'h1;
    walk("walk_wide", 257, NOM2 + 28'hBE);
    // chip stream from the host model at 16 steps per chip
    wr(`FGM_ADDR_STEP_DIV_LO, 8'h02);
    wr(`FGM_ADDR_SHAPE_CFG, 8'h00);
    run <= 1'h1;
    for (int c = 0; c < 240; c++)
    begin
      look(1);
      chk("range", 28'h1, 28'(o_div_word >= NOM2 - 28'hBE && o_div_word <= NOM2 + 28'hBE));
    end
    @(posedge i_clock);
    run <= 1'h0;
    look(100);
    chk("stream_end", NOM2 + 28'hBE, o_div_word);
    @(posedge i_clock);
    // channel c word bytes and status, then a mid-run reset
    wr(`FGM_ADDR_CHAN_BASE + 8'h08, 8'h41);
    wr(`FGM_ADDR_CHAN_BASE + 8'h09, 8'h34);
    wr(`FGM_ADDR_CHAN_BASE + 8'h0A, 8'h12);
    wr(`FGM_ADDR_FRAC_TOP_C, 8'h05);
    i_channel <= 2'h2;
    look(3);
    chk("nominal_c", 28'h825_12F2, o_div_word);
    @(posedge i_clock);
    rd(`FGM_ADDR_STATUS);
    chk("status_hold", 28'h42, rd_val);
    // read data stand one cycle only
    look(0);
    chk("rdata_back", 28'h0, o_rdata);
    @(posedge i_clock);
    i_reset_n <= 1'h0;
    look(2);
    chk("word_in_reset", 28'h0, o_div_word);
    chk("fsk_in_reset", 28'h0, o_fsk_mode);
    @(posedge i_clock);
    i_reset_n <= 1'h1;
    look(2);
    chk("shaping_after", 28'h1, o_shaping);
    @(posedge i_clock);
    rd(`FGM_ADDR_DEV);
    chk("dev_reset", 28'hDF, rd_val);
    rd(`FGM_ADDR_STEP_DIV_LO);
    chk("div_reset", 28'h08, rd_val);
    rd(`FGM_ADDR_FRAC_TOP_C);
    chk("frac_top_c_reset", 28'h10, rd_val);
    stop_test();
  end
endmodule
`default_nettype wire
